//--- core/asrp_clock_divider.sv
`timescale 1ns/1ps
`include "asrp_defines.svh"

module asrp_clock_divider #(
    parameter int DIV_SEL_W = `ASRP_DIV_SEL_W,
    parameter int CNT_W = `ASRP_DIV_CNT_W,
    parameter logic [CNT_W-1:0] BASE = CNT_W'(`ASRP_DIV_BASE)
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run,
    input wire logic [DIV_SEL_W-1:0] divSel,
    output logic halfTick
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic next_halfTick;
    logic [CNT_W-1:0] halfPeriod;

    always_comb begin
        halfPeriod = CNT_W'(BASE << divSel);
        next_count = count;
        next_halfTick = 1'b0;
        if (!run) begin
            next_count = '0;
        end else if (count == halfPeriod - CNT_W'(1)) begin
            // slower serial clock for slow hosts
            next_count = '0;
            next_halfTick = 1'b1;
        end else begin
            next_count = count + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count <= '0;
            halfTick <= 1'b0;
        end else begin
            count <= next_count;
            halfTick <= next_halfTick;
        end
    end

    chk_tick_spacing: assert property (@(posedge clk_sys) disable iff (rst)
        halfTick |=> !halfTick)
        else $error("serial clock half period shorter than two cycles");

endmodule : asrp_clock_divider

//--- core/asrp_defines.svh
`ifndef ASRP_DEFINES_SVH
`define ASRP_DEFINES_SVH

// conversion result width and bit counter width
`define ASRP_RESULT_BITS 18
`define ASRP_CNT_W 5
// last bit index of the result
`define ASRP_MSB 17
// master clock: half period is BASE << divider select, in clk_sys cycles
`define ASRP_DIV_SEL_W 2
`define ASRP_DIV_BASE 2
`define ASRP_DIV_CNT_W 5
// fastest external serial clock accepted in slave mode
`define ASRP_SCLK_MAX_MHZ 40
`define ASRP_CLK_MHZ 125

`endif

//--- core/asrp_pkg.sv
package asrp_pkg;

    typedef enum logic [1:0] {
        ASRP_M_IDLE  = 2'b01,
        ASRP_M_SHIFT = 2'b10
    } asrp_mst_e;

endpackage : asrp_pkg

//--- core/asrp_serial_port.sv
// How it works
// - clock select low: device is master and makes the serial clock
// - master drives a frame-valid output while shifted data is valid
// - master can invert generated serial clock and frame-valid polarity
// - master read-timing input picks read after or during conversion
// - master read-after mode keeps busy high until all 18 bits sent
// - master serial clock is slowed by the divider select inputs
// - clock select high: device is slave and shifts on external clock
// - external clock gated by chip select; shift only when select and read low
// - slave accepts continuous or discontinuous clock idling high or low
// - slave read-after: after busy falls, 18 bits MSB first
// - slave read-after supports external clock up to 40 MHz
// - slave read-after reuses the read-timing pin as chain input
// - chain input sampled on opposite edge; upstream MSB follows local LSB
// - slave read-during shifts previous result; host finishes before done
// - unfinished slave read of previous result at conversion end pulses read overrun
// - a slave read begun after conversion may continue into the next one
// - serial interface only when both interface selects are high
// - outputs high impedance while chip select or read is high
`timescale 1ns/1ps
`include "asrp_defines.svh"

module asrp_serial_port #(
    parameter int BITS = `ASRP_RESULT_BITS,
    parameter int CNT_W = `ASRP_CNT_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic interfaceSelectLo,
    input wire logic interfaceSelectHi,
    input wire logic clockSourceSelect,
    input wire logic readTimingOrChainIn,
    input wire logic [`ASRP_DIV_SEL_W-1:0] clockDividerSelect,
    input wire logic invertClock,
    input wire logic invertFrame,
    input wire logic chipSelect_n,
    input wire logic read_n,
    input wire logic serialClockIn,
    input wire logic convertStart_n,
    input wire logic convDone,
    input wire logic [BITS-1:0] convResult,
    output logic busy,
    output logic serialClockOut,
    output logic serialClockOe,
    output logic frameValid,
    output logic frameValidOe,
    output logic serialDataOut,
    output logic serialDataOe,
    output logic readOverrunPulse
);

    localparam logic [CNT_W-1:0] LAST = CNT_W'(BITS);

    logic serialOn;
    logic isMaster;
    logic readDuring;
    logic pinsOpen;
    logic slaveRise;
    logic slaveFall;
    logic halfTick;

    // conversion and busy state
    logic convRunning;
    logic next_convRunning;
    logic cnvPrev;
    logic next_busy;

    // shifter state
    asrp_pkg::asrp_mst_e mState;
    asrp_pkg::asrp_mst_e next_mState;
    logic [BITS-1:0] shifter;
    logic [BITS-1:0] next_shifter;
    logic [CNT_W-1:0] bitCount;
    logic [CNT_W-1:0] next_bitCount;
    logic mClk;
    logic next_mClk;
    logic chainBit;
    logic next_chainBit;
    logic sclkPrev;
    logic next_overrun;

    // pin registers
    logic next_sclkPin;
    logic next_framePin;
    logic next_clkOe;
    logic next_dataOe;

    assign serialOn = interfaceSelectLo & interfaceSelectHi;
    assign isMaster = ~clockSourceSelect;
    assign readDuring = readTimingOrChainIn;
    assign pinsOpen = serialOn & ~chipSelect_n & ~read_n;
    // single sample per edge is enough: a 40 MHz half period exceeds 8 ns
    assign slaveRise = ~isMaster & pinsOpen & ~sclkPrev & serialClockIn;
    assign slaveFall = ~isMaster & pinsOpen & sclkPrev & ~serialClockIn;

    asrp_clock_divider #(
        .DIV_SEL_W(`ASRP_DIV_SEL_W),
        .CNT_W(`ASRP_DIV_CNT_W),
        .BASE(`ASRP_DIV_CNT_W'(`ASRP_DIV_BASE))
    ) u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(mState == asrp_pkg::ASRP_M_SHIFT),
        .divSel(clockDividerSelect),
        .halfTick(halfTick)
    );

    always_comb begin
        next_convRunning = convRunning;
        if (convDone) begin
            next_convRunning = 1'b0;
        end else if (cnvPrev && !convertStart_n && !busy) begin
            next_convRunning = 1'b1;
        end
        // busy stretched over the master read-after transfer
        next_busy = next_convRunning
            | (isMaster & serialOn & ~readDuring
               & (next_mState == asrp_pkg::ASRP_M_SHIFT));
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            convRunning <= 1'b0;
            cnvPrev <= 1'b1;
            busy <= 1'b0;
        end else begin
            convRunning <= next_convRunning;
            cnvPrev <= convertStart_n;
            busy <= next_busy;
        end
    end

    always_comb begin
        next_mState = mState;
        next_shifter = shifter;
        next_bitCount = bitCount;
        next_mClk = mClk;
        next_chainBit = chainBit;
        next_overrun = 1'b0;
        unique case (mState)
            asrp_pkg::ASRP_M_IDLE: begin
                next_mClk = 1'b0;
                if (isMaster && serialOn) begin
                    // read-during starts at conversion start, old result
                    if (readDuring && cnvPrev && !convertStart_n
                        && !busy) begin
                        next_mState = asrp_pkg::ASRP_M_SHIFT;
                        next_bitCount = '0;
                    end else if (!readDuring && convDone) begin
                        next_mState = asrp_pkg::ASRP_M_SHIFT;
                    end
                end
            end
            asrp_pkg::ASRP_M_SHIFT: begin
                if (halfTick) begin
                    next_mClk = ~mClk;
                    if (!mClk) begin
                        next_bitCount = bitCount + CNT_W'(1);
                    end else if (bitCount == LAST) begin
                        next_mState = asrp_pkg::ASRP_M_IDLE;
                    end else begin
                        next_shifter = {shifter[BITS-2:0], 1'b0};
                    end
                end
                if (!isMaster || !serialOn) begin
                    next_mState = asrp_pkg::ASRP_M_IDLE;
                end
            end
        endcase
        // chain input latched on the edge opposite the shift edge
        if (slaveFall) begin
            next_chainBit = readTimingOrChainIn;
        end
        // first rise presents the MSB, later rises shift
        if (slaveRise) begin
            if (bitCount != '0) begin
                next_shifter = {shifter[BITS-2:0], chainBit};
            end
            if (bitCount != LAST) begin
                next_bitCount = bitCount + CNT_W'(1);
            end
        end
        // load only at conversion end, so a late read keeps going
        if (convDone) begin
            next_shifter = convResult;
            next_bitCount = '0;
            // partial slave read cut short by the new result
            next_overrun = ~isMaster & serialOn
                & (bitCount != '0) & (bitCount != LAST);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mState <= asrp_pkg::ASRP_M_IDLE;
            shifter <= '0;
            bitCount <= '0;
            mClk <= 1'b0;
            chainBit <= 1'b0;
            sclkPrev <= 1'b0;
            readOverrunPulse <= 1'b0;
        end else begin
            mState <= next_mState;
            shifter <= next_shifter;
            bitCount <= next_bitCount;
            mClk <= next_mClk;
            chainBit <= next_chainBit;
            sclkPrev <= serialClockIn;
            readOverrunPulse <= next_overrun;
        end
    end

    always_comb begin
        next_sclkPin = next_mClk ^ invertClock;
        next_framePin = (next_mState == asrp_pkg::ASRP_M_SHIFT)
            ^ invertFrame;
        // clock and frame are only driven by a master
        next_clkOe = isMaster & pinsOpen;
        next_dataOe = pinsOpen;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serialClockOut <= 1'b0;
            serialClockOe <= 1'b0;
            frameValid <= 1'b0;
            frameValidOe <= 1'b0;
            serialDataOut <= 1'b0;
            serialDataOe <= 1'b0;
        end else begin
            serialClockOut <= next_sclkPin;
            serialClockOe <= next_clkOe;
            frameValid <= next_framePin;
            frameValidOe <= next_clkOe;
            serialDataOut <= next_shifter[BITS-1];
            serialDataOe <= next_dataOe;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_busy_hold: assert property (
        (mState == asrp_pkg::ASRP_M_SHIFT && isMaster && serialOn
         && !readDuring && $stable(readDuring)) |-> busy)
        else $error("busy fell before master read-after transfer ended");

    chk_frame_level: assert property (
        (mState == asrp_pkg::ASRP_M_SHIFT && $stable(invertFrame)
         && next_mState == asrp_pkg::ASRP_M_SHIFT)
        |=> frameValid == !invertFrame)
        else $error("frame valid not asserted while shifting");

    chk_clock_idle: assert property (
        (mState == asrp_pkg::ASRP_M_IDLE && $stable(invertClock))
        [*2] |-> serialClockOut == invertClock)
        else $error("idle master clock has wrong polarity");

    chk_result_load: assert property (
        convDone |=> shifter == $past(convResult) && bitCount == '0)
        else $error("result not loaded at conversion end");

    chk_slave_step: assert property (
        (slaveRise && !convDone && bitCount != LAST)
        |=> bitCount == $past(bitCount) + CNT_W'(1))
        else $error("slave rise did not advance bit count");

    chk_overrun_pulse: assert property (
        (convDone && !isMaster && serialOn && bitCount != '0
         && bitCount != LAST) |=> readOverrunPulse ##1 !readOverrunPulse)
        else $error("overrun not pulsed for one cycle");

    chk_release_pins: assert property (
        (chipSelect_n || read_n) |=> !serialDataOe && !serialClockOe)
        else $error("pins driven while select or read high");

    chk_mode_gate: assert property (
        !(interfaceSelectLo && interfaceSelectHi)
        |=> !serialDataOe && mState == asrp_pkg::ASRP_M_IDLE)
        else $error("serial port active outside serial mode");

    chk_slave_clock: assert property (
        clockSourceSelect |=> !serialClockOe && !frameValidOe)
        else $error("slave drives the serial clock");

    cov_master_frame: cover property (
        mState == asrp_pkg::ASRP_M_SHIFT ##1
        mState == asrp_pkg::ASRP_M_IDLE);
    cov_slave_full: cover property (slaveRise && bitCount == LAST);
    cov_overrun: cover property (readOverrunPulse);

endmodule : asrp_serial_port

//--- testbench/asrp_host_model.sv
`timescale 1ns/1ps
module asrp_host_model (
    input wire logic clk_sys,
    input wire logic serialDataOut,
    input wire logic serialClockOut,
    input wire logic serialDataOe,
    output logic serialClockIn,
    output logic chipSelect_n,
    output logic read_n,
    output logic [23:0] word,
    output logic done,
    output logic [7:0] period
);
    // released data pin reads inverted, so a late enable shows as bad bits
    wire sdoSeen = serialDataOe ? serialDataOut : ~serialDataOut;

    initial begin
        serialClockIn = 1'b0;
        chipSelect_n = 1'b1;
        read_n = 1'b1;
        word = 24'h0;
        done = 1'b0;
        period = 8'h0;
    end

    task automatic pulse_done();
        done = 1'b1;
        @(negedge clk_sys);
        done = 1'b0;
        chipSelect_n = 1'b1;
        read_n = 1'b1;
    endtask : pulse_done

    // clock rests at idle between bursts; sample late in the high phase
    task automatic slave_read(input int n, input logic idle, input int half);
        word = 24'h0;
        serialClockIn = idle;
        @(negedge clk_sys);
        chipSelect_n = 1'b0;
        read_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        for (int i = 0; i < 2 * n; i++) begin
            serialClockIn = ~serialClockIn;
            repeat (half) @(negedge clk_sys);
            if (serialClockIn) word = {word[22:0], sdoSeen};
        end
        pulse_done();
    endtask : slave_read

    // take a bit on each active rise; keep the spacing of the last two
    task automatic master_read(input int n, input logic inv);
        logic prev;
        int gap;
        word = 24'h0;
        gap = 0;
        prev = 1'b1;
        chipSelect_n = 1'b0;
        read_n = 1'b0;
        for (int i = 0; i < n;) begin
            @(negedge clk_sys);
            gap++;
            if ((serialClockOut ^ inv) && !prev) begin
                word = {word[22:0], sdoSeen};
                period = 8'(gap);
                gap = 0;
                i++;
            end
            prev = serialClockOut ^ inv;
        end
        pulse_done();
    endtask : master_read
endmodule : asrp_host_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_sys, rst, interfaceSelectLo, interfaceSelectHi;
    logic clockSourceSelect, readTimingOrChainIn, invertClock;
    logic invertFrame, chipSelect_n, read_n, serialClockIn;
    logic convertStart_n, convDone, busy, serialClockOut;
    logic serialClockOe, frameValid, frameValidOe, serialDataOut;
    logic serialDataOe, readOverrunPulse, done;
    logic [1:0] clockDividerSelect;
    logic [17:0] convResult;
    logic [23:0] word;
    logic [7:0] period;
    logic [23:0] expQ[$];
    int nMismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    int ovr = 0;

    asrp_serial_port u_asrp_serial_port (
        .clk_sys, .rst, .interfaceSelectLo, .interfaceSelectHi,
        .clockSourceSelect, .readTimingOrChainIn, .clockDividerSelect,
        .invertClock, .invertFrame, .chipSelect_n, .read_n,
        .serialClockIn, .convertStart_n, .convDone, .convResult, .busy,
        .serialClockOut, .serialClockOe, .frameValid, .frameValidOe,
        .serialDataOut, .serialDataOe, .readOverrunPulse
    );

    asrp_host_model u_asrp_host_model (
        .clk_sys, .serialDataOut, .serialClockOut, .serialDataOe,
        .serialClockIn,
        .chipSelect_n, .read_n, .word, .done, .period
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    task automatic chk(input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e) begin
            nMismatch++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    // hang guard, well above the longest expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            nMismatch++;
            final_report();
        end
    end

    always @(posedge clk_sys) begin
        if (readOverrunPulse === 1'b1) ovr++;
        if (done === 1'b1) chk(expQ.pop_front(), word);
    end

    task automatic start_conv();
        while (busy !== 1'b0) @(negedge clk_sys);
        convertStart_n = 1'b0;
        @(negedge clk_sys);
        convertStart_n = 1'b1;
        @(negedge clk_sys);
        chk(24'h1, 24'(busy));
    endtask : start_conv

    task automatic finish_conv(input logic [17:0] r, input int d);
        repeat (d) @(negedge clk_sys);
        convResult = r;
        convDone = 1'b1;
        @(negedge clk_sys);
        convDone = 1'b0;
    endtask : finish_conv

    initial begin
        logic [17:0] a, b;
        logic c;
        rst = 1'b1;
        convertStart_n = 1'b1;
        convDone = 1'b0;
        convResult = 18'h0;
        interfaceSelectLo = 1'b1;
        interfaceSelectHi = 1'b1;
        clockSourceSelect = 1'b1;
        readTimingOrChainIn = 1'b0;
        clockDividerSelect = 2'h0;
        invertClock = 1'b0;
        invertFrame = 1'b0;
        void'($urandom(32'h15c5));
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        c = 1'($urandom);
        a = 18'($urandom);
        b = 18'($urandom);
        readTimingOrChainIn = c;
        start_conv();
        finish_conv(a, 30);
        expQ.push_back({a, {6{c}}});
        u_asrp_host_model.slave_read(24, 1'b0, 2);
        $display("test slave_chain done");
        start_conv();
        finish_conv(b, 30);
        expQ.push_back(24'(b));
        u_asrp_host_model.slave_read(18, 1'b1, 2);
        $display("test slave_idle_high done");
        start_conv();
        finish_conv(a, 30);
        expQ.push_back(24'(a));
        fork
            u_asrp_host_model.slave_read(18, 1'b0, 2);
            begin
                repeat (20) @(negedge clk_sys);
                start_conv();
            end
        join
        finish_conv(b, 5);
        repeat (3) @(negedge clk_sys);
        chk(24'h0, 24'(ovr));
        start_conv();
        expQ.push_back(24'(b >> 13));
        u_asrp_host_model.slave_read(5, 1'b0, 2);
        finish_conv(a, 5);
        repeat (3) @(negedge clk_sys);
        chk(24'h1, 24'(ovr));
        chk(24'h0, 24'(serialDataOe));
        $display("test slave_during done");
        clockSourceSelect = 1'b0;
        for (int i = 0; i < 4; i++) begin
            clockDividerSelect = 2'(i);
            invertClock = i[1];
            invertFrame = i[1];
            a = 18'($urandom);
            b = 18'($urandom);
            readTimingOrChainIn = 1'b0;
            start_conv();
            finish_conv(a, 20);
            expQ.push_back(24'(a));
            u_asrp_host_model.master_read(18, invertClock);
            chk(24'h1, 24'(busy));
            chk(24'(!invertFrame), 24'(frameValid));
            chk(24'(4 << i), 24'(period));
            readTimingOrChainIn = 1'b1;
            start_conv();
            finish_conv(b, 700);
            start_conv();
            expQ.push_back(24'(b));
            u_asrp_host_model.master_read(18, invertClock);
            // let the slowest master frame finish before the next load
            finish_conv(a, 40);
            $display("test master_div%0d done", i);
        end
        interfaceSelectHi = 1'b0;
        readTimingOrChainIn = 1'b0;
        start_conv();
        finish_conv(a, 5);
        @(negedge clk_sys);
        chk(24'h0, 24'(busy));
        chk(24'(invertFrame), 24'(frameValid));
        $display("test serial_off done");
        repeat (10) @(negedge clk_sys);
        final_report();
    end
endmodule : tb
